/* pkg/scc_defines.svh */
// register offsets, field positions, reset values and counts for the clock config block
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH

`define SCC_AW            10
`define SCC_A_SERIAL_OPT  10'h004
`define SCC_A_UPDATE      10'h005
`define SCC_A_RESET_CTL   10'h013
`define SCC_A_NDIV        10'h020
`define SCC_A_RSVD_PLL    10'h021
`define SCC_A_PLL         10'h022
`define SCC_A_SDIV_LO     10'h104
`define SCC_A_SDIV_HI     10'h105
`define SCC_A_SDIV_CTL    10'h106
`define SCC_A_TUNING_WORD_BYTE        10'h1a6
`define SCC_FTW_BYTES     6

`define SCC_B_READ_BUF    0
`define SCC_B_UPDATE      0
`define SCC_B_SDIV_RST    1
`define SCC_B_PRE_RST     3
`define SCC_B_VCO_AUTO    7
`define SCC_B_REF_DBL     3
`define SCC_B_VCO_RANGE   2
`define SCC_B_PRESCALE    0
`define SCC_B_INVERT      7

`define SCC_NDIV_MASK     8'h1f
`define SCC_PLL_MASK      8'h8f
`define SCC_SDIV_CTL_MASK 8'h81
`define SCC_RESET_MASK    8'h0a
`define SCC_NDIV_OFFSET   6'h02

`define SCC_CP_250        2'h0
`define SCC_CP_375        2'h1
`define SCC_CP_OFF        2'h2
`define SCC_CP_125        2'h3
`define SCC_UA_250        9'h0fa
`define SCC_UA_375        9'h177
`define SCC_UA_125        9'h07d
`define SCC_UA_OFF        9'h000

`define SCC_CFG_RESET     8'h00
`define SCC_STRAP_WAIT    2'h3
`define SCC_STRAP_PAD     44'h0

`define SCC_SYN_W         7
`define SCC_SYN_DIV       0
`define SCC_SYN_CAL       1
`define SCC_SYN_UPD       2
`define SCC_SYN_STRAP     3

`endif

/* pkg/scc_pkg.sv */
// state types for the clock config block
package scc_pkg;

  typedef struct packed {
    logic [7:0]  ndiv;
    logic [7:0]  pll;
    logic [7:0]  sdiv_lo;
    logic [7:0]  sdiv_hi;
    logic [7:0]  sdiv_ctl;
    logic [47:0] freq_tuning_word;
  } scc_cfg_s;

  typedef struct packed {
    scc_cfg_s    bufr;
    scc_cfg_s    act;
    logic        read_buf;
    logic [7:0]  reset_ctl;
    logic [6:0]  s1;
    logic [6:0]  s2;
    logic [6:0]  s3;
    logic [6:0]  filt;
    logic        upd_prev;
    logic [1:0]  strap_cnt;
    logic        strapped;
    logic [47:0] phase;
    logic [7:0]  rdata;
    logic [6:0]  fb_ratio;
    logic [8:0]  cp_ua;
  } scc_top_s;

  typedef struct packed {
    logic        prev_in;
    logic        pre_q;
    logic        prev_pre;
    logic [15:0] cnt;
    logic        out;
  } scc_div_s;

endpackage

/* pkg/scc_div_if.sv */
// signals between the register block and the output divider
`timescale 1ns/1ps
interface scc_div_if;
  logic [15:0] ratio_m1;
  logic        prescale_en;
  logic        invert;
  logic        pre_rst;
  logic        div_rst;
  logic        in_level;
  logic        out_pulse;

  modport ctl (output ratio_m1, output prescale_en, output invert, output pre_rst, output div_rst,
               output in_level, input out_pulse);
  modport div (input ratio_m1, input prescale_en, input invert, input pre_rst, input div_rst,
               input in_level, output out_pulse);
endinterface

/* rtl/scc_out_div.sv */
// output clock divider with optional divide-by-2 prescaler
`timescale 1ns/1ps
`include "scc_defines.svh"
module scc_out_div (
  // clock and reset
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  // control and divider data
  scc_div_if.div    dif
);
  scc_pkg::scc_div_s st;
  scc_pkg::scc_div_s next_st;
  logic              in_eff;
  logic              in_edge;
  logic              tick;

  always_comb begin
    next_st = st;
    in_eff = dif.invert ? ~dif.in_level : dif.in_level;
    in_edge = in_eff & ~st.prev_in;
    next_st.prev_in = in_eff;
    next_st.out = 1'b0;
    if (dif.pre_rst) begin
      next_st.pre_q = 1'b0;
    end else if (in_edge) begin
      next_st.pre_q = ~st.pre_q;
    end
    next_st.prev_pre = st.pre_q;
    tick = dif.prescale_en ? (st.pre_q & ~st.prev_pre) : in_edge;
    if (tick) begin
      if (dif.div_rst) begin
        next_st.cnt = 16'h0000;
      end else if (st.cnt >= dif.ratio_m1) begin
        next_st.cnt = 16'h0000;
        next_st.out = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dif.out_pulse = st.out;
endmodule // scc_out_div

/* rtl/scc_regs.sv */
// clock configuration registers, tuning word and phase accumulator
//
// How it works
// - feedback ratio is two times (value+2)
// - auto range sets range bit itself
// - bit 3 enables reference doubler
// - range bit: low or high VCO
// - charge pump code to current map
// - output divider divides by value+1
// - control bit 0 adds /2 prescaler
// - control bit 7 inverts divider input
// - tuning word sets output-to-clock ratio
// - new word keeps phase accumulator continuous
// - startup pins set word default
// - update bit transfers buffers to active
// - divider reset synchronous to prescaler
// - prescaler reset acts immediately
`timescale 1ns/1ps
`include "scc_defines.svh"
module scc_regs (
  // clock and reset
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST_N,
  // register port
  input  wire logic [`SCC_AW-1:0]   REG_ADDR,
  input  wire logic [7:0]           REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic      [7:0]           REG_RDATA,
  // pins from outside
  input  wire logic                 IO_UPDATE,
  input  wire logic [3:0]           STARTUP_PIN,
  input  wire logic                 VCO_CAL_HIGH,
  input  wire logic                 DIV_IN,
  // pll controls
  output logic      [6:0]           FEEDBACK_RATIO,
  output logic                      REF_DOUBLER_EN,
  output logic                      VCO_RANGE_HIGH,
  output logic      [8:0]           CP_CURRENT_UA,
  // output divider
  output logic                      DIV_OUT,
  // synthesis
  output logic      [47:0]          FREQ_TUNING_WORD,
  output logic      [47:0]          PHASE_ACC
);
  scc_pkg::scc_top_s st;
  scc_pkg::scc_top_s next_st;
  scc_pkg::scc_cfg_s rd_cfg;
  logic [6:0]        raw_in;
  logic              upd_pulse;
  logic [5:0]        fb_half;

  scc_div_if dif ();

  assign raw_in = {STARTUP_PIN, IO_UPDATE, VCO_CAL_HIGH, DIV_IN};

  always_comb begin
    next_st = st;
    upd_pulse = 1'b0;
    fb_half = 6'h00;
    rd_cfg = st.read_buf ? st.bufr : st.act;

    // three-stage pin sampling; a change counts when stages two and three agree
    next_st.s1 = raw_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < `SCC_SYN_W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.filt[i] = st.s3[i];
      end
    end
    next_st.upd_prev = st.filt[`SCC_SYN_UPD];
    if (st.filt[`SCC_SYN_UPD] && !st.upd_prev) begin
      upd_pulse = 1'b1;
    end

    // ndiv, pll, divider and tuning word writes land in the buffer set
    if (REG_WR) begin
      case (REG_ADDR)
        `SCC_A_SERIAL_OPT: begin
          next_st.read_buf = REG_WDATA[`SCC_B_READ_BUF];
        end
        `SCC_A_UPDATE: begin
          if (REG_WDATA[`SCC_B_UPDATE]) begin
            upd_pulse = 1'b1;
          end
        end
        `SCC_A_RESET_CTL: begin
          next_st.reset_ctl = REG_WDATA & `SCC_RESET_MASK;
        end
        `SCC_A_NDIV: begin
          next_st.bufr.ndiv = REG_WDATA & `SCC_NDIV_MASK;
        end
        `SCC_A_PLL: begin
          next_st.bufr.pll = REG_WDATA & `SCC_PLL_MASK;
        end
        `SCC_A_SDIV_LO: begin
          next_st.bufr.sdiv_lo = REG_WDATA;
        end
        `SCC_A_SDIV_HI: begin
          next_st.bufr.sdiv_hi = REG_WDATA;
        end
        `SCC_A_SDIV_CTL: begin
          next_st.bufr.sdiv_ctl = REG_WDATA & `SCC_SDIV_CTL_MASK;
        end
        default: begin
          // six tuning word bytes, lsb first
          for (int i = 0; i < `SCC_FTW_BYTES; i++) begin
            if (REG_ADDR == `SCC_A_TUNING_WORD_BYTE + `SCC_AW'(i)) begin
              next_st.bufr.freq_tuning_word[i*8 +: 8] = REG_WDATA;
            end
          end
        end
      endcase
    end

    if (upd_pulse) begin
      next_st.act = next_st.bufr;
    end

    if (!st.strapped) begin
      if (st.strap_cnt == `SCC_STRAP_WAIT) begin
        next_st.strapped = 1'b1;
        // filter register lags a cycle; take the value it settles to now
        next_st.bufr.freq_tuning_word = {next_st.filt[`SCC_SYN_STRAP +: 4], `SCC_STRAP_PAD};
        next_st.act.freq_tuning_word = {next_st.filt[`SCC_SYN_STRAP +: 4], `SCC_STRAP_PAD};
      end else begin
        next_st.strap_cnt = st.strap_cnt + 2'h1;
      end
    end

    // calibrator drives range bit in auto mode
    if (next_st.act.pll[`SCC_B_VCO_AUTO]) begin
      next_st.act.pll[`SCC_B_VCO_RANGE] = st.filt[`SCC_SYN_CAL];
    end

    // fixed /2 then value plus two
    fb_half = {1'b0, st.act.ndiv[4:0]} + `SCC_NDIV_OFFSET;
    next_st.fb_ratio = {fb_half, 1'b0};

    case (st.act.pll[1:0])
      `SCC_CP_250: next_st.cp_ua = `SCC_UA_250;
      `SCC_CP_375: next_st.cp_ua = `SCC_UA_375;
      `SCC_CP_OFF: next_st.cp_ua = `SCC_UA_OFF;
      `SCC_CP_125: next_st.cp_ua = `SCC_UA_125;
      default:     next_st.cp_ua = `SCC_UA_OFF;
    endcase

    // accumulator never reloaded on word change
    next_st.phase = st.phase + st.act.freq_tuning_word;

    // readback; reserved and unmapped addresses read zero
    if (REG_RD) begin
      case (REG_ADDR)
        `SCC_A_SERIAL_OPT: next_st.rdata = {7'h00, st.read_buf};
        `SCC_A_RESET_CTL:  next_st.rdata = st.reset_ctl;
        `SCC_A_NDIV:       next_st.rdata = rd_cfg.ndiv;
        `SCC_A_PLL:        next_st.rdata = rd_cfg.pll;
        `SCC_A_SDIV_LO:    next_st.rdata = rd_cfg.sdiv_lo;
        `SCC_A_SDIV_HI:    next_st.rdata = rd_cfg.sdiv_hi;
        `SCC_A_SDIV_CTL:   next_st.rdata = rd_cfg.sdiv_ctl;
        default: begin
          next_st.rdata = 8'h00;
          for (int i = 0; i < `SCC_FTW_BYTES; i++) begin
            if (REG_ADDR == `SCC_A_TUNING_WORD_BYTE + `SCC_AW'(i)) begin
              next_st.rdata = rd_cfg.freq_tuning_word[i*8 +: 8];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // divider follows active copy; the prescaler bit is not checked against ratio,
  // software owns that choice
  // lsb byte at lower address
  assign dif.ratio_m1 = {st.act.sdiv_hi, st.act.sdiv_lo};
  assign dif.prescale_en = st.act.sdiv_ctl[`SCC_B_PRESCALE];
  assign dif.invert = st.act.sdiv_ctl[`SCC_B_INVERT];
  assign dif.pre_rst = st.reset_ctl[`SCC_B_PRE_RST];
  assign dif.div_rst = st.reset_ctl[`SCC_B_SDIV_RST];
  assign dif.in_level = st.filt[`SCC_SYN_DIV];

  scc_out_div u_div (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .dif     (dif.div)
  );

  assign REG_RDATA = st.rdata;
  assign FEEDBACK_RATIO = st.fb_ratio;
  assign REF_DOUBLER_EN = st.act.pll[`SCC_B_REF_DBL];
  assign VCO_RANGE_HIGH = st.act.pll[`SCC_B_VCO_RANGE];
  assign CP_CURRENT_UA = st.cp_ua;
  assign DIV_OUT = dif.out_pulse;
  assign FREQ_TUNING_WORD = st.act.freq_tuning_word;
  assign PHASE_ACC = st.phase;
endmodule // scc_regs

/* dv/scc_regs_asserts.sv */
// port checker for the clock config register block
`timescale 1ns/1ps
`include "scc_defines.svh"
module scc_regs_asserts (
  // clock and reset
  input wire logic                SYS_CLK,
  input wire logic                RST_N,
  // register port
  input wire logic [`SCC_AW-1:0]  REG_ADDR,
  input wire logic                REG_RD,
  input wire logic [7:0]          REG_RDATA,
  // outputs
  input wire logic [6:0]          FEEDBACK_RATIO,
  input wire logic [8:0]          CP_CURRENT_UA,
  input wire logic                DIV_OUT,
  input wire logic [47:0]         FREQ_TUNING_WORD,
  input wire logic [47:0]         PHASE_ACC
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  rsvd_read_zero_a: assert property (REG_RD && REG_ADDR == `SCC_A_RSVD_PLL |=> REG_RDATA == 8'h00)
    else $error("reserved slot read not zero");
  update_self_clear_a: assert property (REG_RD && REG_ADDR == `SCC_A_UPDATE |=> REG_RDATA == 8'h00)
    else $error("update bit did not clear");
  ctl_bits_masked_a: assert property (REG_RD && REG_ADDR == `SCC_A_SDIV_CTL |=> (REG_RDATA & 8'h7e) == 8'h00)
    else $error("divider control reserved bits set");
  pll_bits_masked_a: assert property (REG_RD && REG_ADDR == `SCC_A_PLL |=> REG_RDATA[6:4] == 3'h0)
    else $error("pll reserved bits set");
  fb_ratio_range_a: assert property (FEEDBACK_RATIO != 7'h00 |-> !FEEDBACK_RATIO[0] &&
    FEEDBACK_RATIO inside {[7'h04:7'h42]}) else $error("feedback ratio out of range");
  cp_code_map_a: assert property (CP_CURRENT_UA inside {9'h0fa, 9'h177, 9'h000, 9'h07d})
    else $error("charge pump current not a listed value");
  phase_step_a: assert property ($past(RST_N) |-> PHASE_ACC == $past(PHASE_ACC) + $past(FREQ_TUNING_WORD))
    else $error("phase accumulator step wrong");
  div_pulse_single_a: assert property (DIV_OUT |=> !DIV_OUT)
    else $error("divider strobe longer than one cycle");

  cover property (DIV_OUT);
  cover property (REG_RD && REG_ADDR == `SCC_A_RSVD_PLL);
  cover property (REG_RD && REG_ADDR == `SCC_A_UPDATE);
endmodule // scc_regs_asserts

/* dv/scc_regs_test.sv */
// self-checking bench for the clock config register block
`timescale 1ns/1ps
`include "scc_defines.svh"
module scc_regs_test;
  logic               SYS_CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0;
  logic               IO_UPDATE = 0, VCO_CAL_HIGH = 0, DIV_IN = 0, DIV_OUT;
  logic               REF_DOUBLER_EN, VCO_RANGE_HIGH;
  logic [`SCC_AW-1:0] REG_ADDR = '0;
  logic [7:0]         REG_WDATA = 8'h00, REG_RDATA, rd_val, d;
  logic [3:0]         STARTUP_PIN = 4'ha;
  logic [6:0]         FEEDBACK_RATIO;
  logic [8:0]         CP_CURRENT_UA;
  logic [47:0]        FREQ_TUNING_WORD, PHASE_ACC, p0;
  logic [8:0]         cp_ua [4] = '{9'h0fa, 9'h177, 9'h000, 9'h07d};
  int                 fail_count = 0, compares = 0, pulses = 0, base;

  scc_regs u_scc_regs (.SYS_CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .IO_UPDATE,
    .STARTUP_PIN, .VCO_CAL_HIGH, .DIV_IN, .FEEDBACK_RATIO, .REF_DOUBLER_EN, .VCO_RANGE_HIGH, .CP_CURRENT_UA,
    .DIV_OUT, .FREQ_TUNING_WORD, .PHASE_ACC);

  initial forever #12.5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) if (DIV_OUT === 1'b1) pulses++;

  task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [`SCC_AW-1:0] a, logic [7:0] v);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic rd(logic [`SCC_AW-1:0] a);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    @(posedge SYS_CLK);
    rd_val = REG_RDATA;
  endtask
  task automatic upd();
    wr(`SCC_A_UPDATE, 8'h01);
    repeat (3) @(posedge SYS_CLK);
  endtask
  // slow divider input, well inside the sampler's reach
  task automatic tog(int n);
    repeat (n) begin
      DIV_IN <= ~DIV_IN;
      repeat (8) @(posedge SYS_CLK);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (8) @(posedge SYS_CLK);
    chk("strap word", {4'ha, 44'h0}, FREQ_TUNING_WORD);
    chk("fb ratio", 7'h04, FEEDBACK_RATIO);
    chk("cp reset", 9'h0fa, CP_CURRENT_UA);
    wr(`SCC_A_NDIV, 8'hff);
    upd();
    chk("fb ratio", 7'h42, FEEDBACK_RATIO);
    rd(`SCC_A_NDIV);
    chk("ndiv", 8'h1f, rd_val);
    $display("test reset and feedback done");
    for (int c = 0; c < 4; c++) begin
      d = {4'h7, c[0], c[1], c[1:0]};
      wr(`SCC_A_PLL, d);
      upd();
      chk("cp", cp_ua[c], CP_CURRENT_UA);
      chk("doubler", c[0], REF_DOUBLER_EN);
      chk("range", c[1], VCO_RANGE_HIGH);
      rd(`SCC_A_PLL);
      chk("pll", {4'h0, d[3:0]}, rd_val);
    end
    VCO_CAL_HIGH <= 1'b1;
    wr(`SCC_A_PLL, 8'h80);
    upd();
    chk("auto hi", 1'b1, VCO_RANGE_HIGH);
    VCO_CAL_HIGH <= 1'b0;
    repeat (6) @(posedge SYS_CLK);
    chk("auto lo", 1'b0, VCO_RANGE_HIGH);
    wr(`SCC_A_PLL, 8'h08);
    chk("no update", 1'b0, REF_DOUBLER_EN);
    rd(`SCC_A_PLL);
    chk("active rb", 8'h80, rd_val);
    wr(`SCC_A_SERIAL_OPT, 8'h01);
    rd(`SCC_A_PLL);
    chk("buffer rb", 8'h08, rd_val);
    wr(`SCC_A_SERIAL_OPT, 8'h00);
    wr(`SCC_A_RSVD_PLL, 8'hff);
    rd(`SCC_A_RSVD_PLL);
    chk("rsvd", 8'h00, rd_val);
    rd(`SCC_A_UPDATE);
    chk("update clear", 8'h00, rd_val);
    $display("test pll done");
    wr(`SCC_A_SDIV_LO, 8'h02);
    wr(`SCC_A_SDIV_CTL, 8'h7e);
    upd();
    base = pulses;
    tog(24);
    chk("div by 3", 4, pulses - base);
    rd(`SCC_A_SDIV_CTL);
    chk("ctl", 8'h00, rd_val);
    wr(`SCC_A_SDIV_CTL, 8'h01);
    upd();
    base = pulses;
    tog(24);
    chk("prescaled", 2, pulses - base);
    wr(`SCC_A_SDIV_LO, 8'h00);
    wr(`SCC_A_SDIV_CTL, 8'h80);
    upd();
    base = pulses;
    tog(1);
    chk("rise ignored", 0, pulses - base);
    base = pulses;
    tog(1);
    chk("fall counted", 1, pulses - base);
    wr(`SCC_A_RESET_CTL, 8'hff);
    rd(`SCC_A_RESET_CTL);
    chk("reset ctl", 8'h0a, rd_val);
    base = pulses;
    tog(4);
    chk("div reset", 0, pulses - base);
    wr(`SCC_A_RESET_CTL, 8'h08);
    wr(`SCC_A_SDIV_CTL, 8'h01);
    upd();
    base = pulses;
    tog(4);
    chk("pre reset", 0, pulses - base);
    wr(`SCC_A_RESET_CTL, 8'h00);
    base = pulses;
    tog(8);
    chk("pre released", 2, pulses - base);
    $display("test divider done");
    for (int i = 0; i < 6; i++) wr(`SCC_AW'(`SCC_A_TUNING_WORD_BYTE + i), 8'(8'h11 * (i + 1)));
    chk("ftw held", {4'ha, 44'h0}, FREQ_TUNING_WORD);
    upd();
    chk("ftw", 48'h665544332211, FREQ_TUNING_WORD);
    p0 = PHASE_ACC;
    @(posedge SYS_CLK);
    chk("phase", p0 + 48'h665544332211, PHASE_ACC);
    wr(`SCC_A_TUNING_WORD_BYTE, 8'h77);
    IO_UPDATE <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    IO_UPDATE <= 1'b0;
    repeat (6) @(posedge SYS_CLK);
    chk("pin update", 48'h665544332277, FREQ_TUNING_WORD);
    $display("test tuning word done");
    close_out();
  end

  initial begin
    repeat (5000) @(posedge SYS_CLK);
    fail_count++;
    close_out();
  end
endmodule // scc_regs_test

bind scc_regs scc_regs_asserts u_scc_regs_asserts (.SYS_CLK, .RST_N, .REG_ADDR, .REG_RD, .REG_RDATA,
  .FEEDBACK_RATIO, .CP_CURRENT_UA, .DIV_OUT, .FREQ_TUNING_WORD, .PHASE_ACC);
